// ===== sesr_cfg_if.sv
// Configuration write carrier between the top and the severity store
`timescale 1ns/1ps
interface sesr_cfg_if;
  import sesr_pkg::*;
  logic wr_en;
  sesr_word_t wr_data;
  logic [3:0] wr_be;
  sesr_word_t severity;
  modport ctrl (output wr_en, output wr_data, output wr_be, input severity);
  modport store (input wr_en, input wr_data, input wr_be, output severity);
endinterface : sesr_cfg_if

// ===== sesr_chk_sva.sv
// Port checker of the severity block
`timescale 1ns/1ps
module sesr_chk
(
  // Clock and resets
  input wire logic clk,
  input wire logic srst,
  input wire logic link_reset,
  input wire logic global_reset_input,
  input wire logic power_on_reset,
  // Watched ports
  input wire logic cfg_rd,
  input wire sesr_pkg::sesr_addr_t cfg_addr,
  input wire sesr_pkg::sesr_word_t cfg_rdata,
  input wire logic cfg_rd_valid,
  input wire logic [31:0] err_event,
  input wire logic [31:0] status_pending,
  input wire logic msg_fatal,
  input wire logic msg_nonfatal,
  input wire sesr_pkg::sesr_ptr_t first_fault_pointer
);
  import sesr_pkg::*;
  wire rst = srst | link_reset | global_reset_input | power_on_reset;
  wire act = |(err_event & 32'h00001E8C);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Event seen, then every status bit stays pending; later events must not
  // move the captured pointer
  sequence held_s;
    err_event != '0 ##1 (status_pending == '1) [*4];
  endsequence
  rd_answer_a:
  assert property (cfg_rd |=> cfg_rd_valid) else $error("no read answer");
  rd_single_a:
  assert property (!cfg_rd |=> !cfg_rd_valid) else $error("stray answer");
  sev_rsvd_a:
  assert property (cfg_rd && cfg_addr == 12'h134 |=>
    (cfg_rdata & 32'hFFFFC011) == '0) else $error("reserved bit set");
  ptr_upper_a:
  assert property (cfg_rd && cfg_addr == 12'h138 |=> cfg_rdata[31:5] == '0)
    else $error("pointer upper bits set");
  no_msg_a:
  assert property (!act |=> !msg_fatal && !msg_nonfatal)
    else $error("message without cause");
  one_msg_a:
  assert property (act |=> msg_fatal || msg_nonfatal)
    else $error("event not reported");
  ptr_hold_a:
  assert property (held_s |->
    first_fault_pointer == $past(first_fault_pointer, 2))
    else $error("held pointer moved");
  rst_clear_a:
  assert property (disable iff (1'h0) rst |=> first_fault_pointer == '0 &&
    !msg_fatal && !msg_nonfatal && !cfg_rd_valid) else $error("reset left");
endmodule : sesr_chk
bind sesr_top sesr_chk sesr_chk_i (.clk, .srst, .link_reset,
  .global_reset_input, .power_on_reset, .cfg_rd, .cfg_addr, .cfg_rdata,
  .cfg_rd_valid, .err_event, .status_pending, .msg_fatal, .msg_nonfatal,
  .first_fault_pointer);

// ===== sesr_first_ptr.sv
// First error pointer capture
`timescale 1ns/1ps
`include "sesr_params.svh"
module sesr_first_ptr
  import sesr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_any,
  // Error events and status
  input wire logic [31:0] err_event,
  input wire logic [31:0] status_pending,
  // Pointer
  output sesr_ptr_t ptr
);
  sesr_ptr_state_t state_reg;
  sesr_ptr_t ptr_reg;
  sesr_ptr_t ptr_next;
  logic any_event;
  logic ptr_released;
  // Lowest set bit wins when several classes fire together
  always_comb
  begin
    ptr_next = ptr_reg;
    for (int i = 31; i >= 0; i--)
      if (err_event[i])
        ptr_next = 5'(i);
  end
  assign any_event = |err_event;
  assign ptr_released = !status_pending[ptr_reg];
  always_ff @(posedge clk)
  begin
    if (rst_any)
    begin
      state_reg <= SESR_IDLE;
      ptr_reg <= 5'h00;
    end
    else
    begin
      unique case (state_reg)
        SESR_IDLE:
          if (any_event)
          begin
            ptr_reg <= ptr_next;
            state_reg <= SESR_HELD;
          end
        SESR_HELD:
          // Held until software clears that status bit
          if (ptr_released && !any_event)
            state_reg <= SESR_IDLE;
          else if (ptr_released)
            ptr_reg <= ptr_next;
      endcase
    end
  end
  assign ptr = ptr_reg;
endmodule : sesr_first_ptr

// ===== sesr_params.svh
// Offsets, field positions and reset values of the secondary severity block
`ifndef SESR_PARAMS_SVH
`define SESR_PARAMS_SVH
`define SESR_SEVERITY_OFFSET 12'h134
`define SESR_POINTER_OFFSET 12'h138
`define SESR_SEVERITY_RESET 32'h00001340
`define SESR_POINTER_RESET 32'h00000000
`define SESR_SEVERITY_WMASK 32'h00003FEE
`define SESR_ACTIVE_MASK 32'h00001E8C
`define SESR_PTR_MSB 4
`define SESR_BIT_PCIX_INTERNAL 13
`define SESR_BIT_SERR 12
`define SESR_BIT_PERR 11
`define SESR_BIT_DISCARD 10
`define SESR_BIT_ADDR 9
`define SESR_BIT_ATTR 8
`define SESR_BIT_DATA 7
`define SESR_BIT_SPLIT_MSG 6
`define SESR_BIT_SPLIT_UNEXP 5
`define SESR_BIT_MABORT 3
`define SESR_BIT_TABORT 2
`define SESR_BIT_SPLIT_MABORT 1
`endif

// ===== sesr_pkg.sv
// Types shared by the secondary severity block
package sesr_pkg;
  typedef logic [31:0] sesr_word_t;
  typedef logic [11:0] sesr_addr_t;
  typedef logic [4:0] sesr_ptr_t;
  typedef enum logic [1:0] {SESR_IDLE, SESR_HELD} sesr_ptr_state_t;
endpackage : sesr_pkg

// ===== sesr_rc_model.sv
// Upstream side that tallies received error messages
`timescale 1ns/1ps
module sesr_rc_model
(
  // Clock and messages
  input wire logic clk,
  input wire logic msg_fatal,
  input wire logic msg_nonfatal,
  // Tallies
  output int n_fatal,
  output int n_nonfatal
);
  initial n_fatal = 0;
  initial n_nonfatal = 0;
  always @(posedge clk)
  begin
    n_fatal <= n_fatal + int'(msg_fatal);
    n_nonfatal <= n_nonfatal + int'(msg_nonfatal);
  end
endmodule : sesr_rc_model

// ===== sesr_severity_store.sv
// Severity register storage with writable mask
`timescale 1ns/1ps
`include "sesr_params.svh"
module sesr_severity_store
  import sesr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_any,
  // Write port
  sesr_cfg_if.store cfg
);
  sesr_word_t sev_reg;
  sesr_word_t sev_next;
  sesr_word_t be_mask;
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_be
      assign be_mask[g*8 +: 8] = {8{cfg.wr_be[g]}};
    end
  endgenerate
  // Reserved bits never take a write
  assign sev_next = (sev_reg & ~(be_mask & `SESR_SEVERITY_WMASK)) |
                    (cfg.wr_data & be_mask & `SESR_SEVERITY_WMASK);
  always_ff @(posedge clk)
  begin
    if (rst_any)
      sev_reg <= `SESR_SEVERITY_RESET;
    else if (cfg.wr_en)
      sev_reg <= sev_next;
  end
  assign cfg.severity = sev_reg;
endmodule : sesr_severity_store

// ===== sesr_top.sv
// Secondary uncorrectable error severity and first error pointer registers
`timescale 1ns/1ps
`include "sesr_params.svh"
// Functional notes
// - Registers at 134h and 138h, 32 bits
// - Severity one reports error as fatal
// - Severity zero reports error as nonfatal
// - Bits 12,11,10,9,7,3,2 map error classes
// - Severity resets to 0000 1340h
// - PCI-X bits read/write, no effect
// - Bits 31:14, 4, 0 read zero
// - Pointer bits 4:0 name first error
// - Pointer register read-only, upper bits zero
// - Link, global, power-on resets restore defaults
module sesr_top
(
  // Clock and resets
  input wire logic clk,
  input wire logic srst,
  input wire logic link_reset,
  input wire logic global_reset_input,
  input wire logic power_on_reset,
  // Configuration access
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire sesr_pkg::sesr_addr_t cfg_addr,
  input wire sesr_pkg::sesr_word_t cfg_wdata,
  input wire logic [3:0] cfg_be,
  output sesr_pkg::sesr_word_t cfg_rdata,
  output logic cfg_rd_valid,
  // Secondary error events and status
  input wire logic [31:0] err_event,
  input wire logic [31:0] status_pending,
  // Error message requests
  output logic msg_fatal,
  output logic msg_nonfatal,
  // Pointer view
  output sesr_pkg::sesr_ptr_t first_fault_pointer
);
  import sesr_pkg::*;
  sesr_cfg_if cfg ();
  logic rst_any;
  logic hit_sev;
  logic hit_ptr;
  sesr_ptr_t ptr;
  sesr_word_t sev_active;
  sesr_word_t sev_view;
  sesr_word_t rdata_next;
  logic fatal_next;
  logic nonfatal_next;
  sesr_word_t cfg_rdata_reg;
  logic cfg_rd_valid_reg;
  logic msg_fatal_reg;
  logic msg_nonfatal_reg;
  sesr_ptr_t ptr_out_reg;
  logic internal_fault_severity;
  logic system_fault_seen_severity;
  logic parity_fault_seen_severity;
  logic delayed_txn_expiry_severity;
  logic address_fault_severity;
  logic attribute_fault_severity;
  logic data_fault_severity;
  logic split_msg_fault_severity;
  logic unexpected_split_severity;
  logic initiator_abort_severity;
  logic responder_abort_severity;
  logic split_initiator_abort_severity;
  assign rst_any = srst | link_reset | global_reset_input |
                   power_on_reset;
  assign hit_sev = (cfg_addr == `SESR_SEVERITY_OFFSET);
  assign hit_ptr = (cfg_addr == `SESR_POINTER_OFFSET);
  // Pointer register has no write path
  assign cfg.wr_en = cfg_wr & hit_sev;
  assign cfg.wr_data = cfg_wdata;
  assign cfg.wr_be = cfg_be;
  sesr_severity_store u_store (
    .clk(clk),
    .rst_any(rst_any),
    .cfg(cfg.store)
  );
  sesr_first_ptr u_ptr (
    .clk(clk),
    .rst_any(rst_any),
    .err_event(err_event),
    .status_pending(status_pending),
    .ptr(ptr)
  );
  // Named views of the severity fields
  assign internal_fault_severity = cfg.severity[`SESR_BIT_PCIX_INTERNAL];
  assign system_fault_seen_severity = cfg.severity[`SESR_BIT_SERR];
  assign parity_fault_seen_severity = cfg.severity[`SESR_BIT_PERR];
  assign delayed_txn_expiry_severity = cfg.severity[`SESR_BIT_DISCARD];
  assign address_fault_severity = cfg.severity[`SESR_BIT_ADDR];
  assign attribute_fault_severity = cfg.severity[`SESR_BIT_ATTR];
  assign data_fault_severity = cfg.severity[`SESR_BIT_DATA];
  assign split_msg_fault_severity = cfg.severity[`SESR_BIT_SPLIT_MSG];
  assign unexpected_split_severity = cfg.severity[`SESR_BIT_SPLIT_UNEXP];
  assign initiator_abort_severity = cfg.severity[`SESR_BIT_MABORT];
  assign responder_abort_severity = cfg.severity[`SESR_BIT_TABORT];
  assign split_initiator_abort_severity =
    cfg.severity[`SESR_BIT_SPLIT_MABORT];
  // PCI-X classes never reach the bridge, so their bits are dropped
  assign sev_active = {18'h00000, 1'b0,
                       system_fault_seen_severity,
                       parity_fault_seen_severity,
                       delayed_txn_expiry_severity,
                       address_fault_severity,
                       1'b0,
                       data_fault_severity,
                       3'h0,
                       initiator_abort_severity,
                       responder_abort_severity,
                       2'h0};
  // Fatal where severity set
  assign fatal_next = |(err_event & sev_active);
  // Nonfatal where severity clear
  assign nonfatal_next = |(err_event & ~sev_active & `SESR_ACTIVE_MASK);
  // Read-back built from the named fields, reserved bits tied low
  assign sev_view = {18'h00000,
                     internal_fault_severity,
                     system_fault_seen_severity,
                     parity_fault_seen_severity,
                     delayed_txn_expiry_severity,
                     address_fault_severity,
                     attribute_fault_severity,
                     data_fault_severity,
                     split_msg_fault_severity,
                     unexpected_split_severity,
                     1'b0,
                     initiator_abort_severity,
                     responder_abort_severity,
                     split_initiator_abort_severity,
                     1'b0};
  // Unmapped offsets read zero
  assign rdata_next = hit_sev ? sev_view :
                      hit_ptr ? {27'h0000000, ptr} : 32'h00000000;
  always_ff @(posedge clk)
  begin
    if (rst_any)
    begin
      cfg_rdata_reg <= 32'h00000000;
      cfg_rd_valid_reg <= 1'b0;
      msg_fatal_reg <= 1'b0;
      msg_nonfatal_reg <= 1'b0;
      ptr_out_reg <= 5'h00;
    end
    else
    begin
      cfg_rd_valid_reg <= cfg_rd;
      if (cfg_rd)
        cfg_rdata_reg <= rdata_next;
      msg_fatal_reg <= fatal_next;
      msg_nonfatal_reg <= nonfatal_next;
      ptr_out_reg <= ptr;
    end
  end
  assign cfg_rdata = cfg_rdata_reg;
  assign cfg_rd_valid = cfg_rd_valid_reg;
  assign msg_fatal = msg_fatal_reg;
  assign msg_nonfatal = msg_nonfatal_reg;
  assign first_fault_pointer = ptr_out_reg;
endmodule : sesr_top

// ===== tb_top.sv
// Self-checking bench for the severity block
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin errors++; \
  $display("wrong value %s exp %h got %h", n, e, a); end end
module tb_top;
  import sesr_pkg::*;
  localparam sesr_word_t act_mask = 32'h00001E8C;
  logic clk = 0, srst = 1, link_reset = 0, global_reset_input = 0;
  logic power_on_reset = 0, cfg_rd = 0, cfg_wr = 0;
  logic cfg_rd_valid, msg_fatal, msg_nonfatal;
  logic [3:0] cfg_be = '0;
  logic [31:0] err_event = '0, status_pending = '0;
  sesr_addr_t cfg_addr = '0;
  sesr_word_t cfg_wdata = '0, cfg_rdata, sev = 32'h00001340;
  sesr_ptr_t first_fault_pointer;
  int errors = 0, compares = 0, cycles = 0, nf, nn, ef = 0, en = 0;
  sesr_top sesr_top_i (.clk, .srst, .link_reset, .global_reset_input,
    .power_on_reset, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_wdata, .cfg_be,
    .cfg_rdata, .cfg_rd_valid, .err_event, .status_pending, .msg_fatal,
    .msg_nonfatal, .first_fault_pointer);
  sesr_rc_model sesr_rc_model_i (.clk, .msg_fatal, .msg_nonfatal,
    .n_fatal(nf), .n_nonfatal(nn));
  initial forever #20 clk = ~clk;
  // Whole run is under two hundred cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      close_out();
    end
  end
  task automatic rd(sesr_addr_t a, sesr_word_t e);
    @(posedge clk);
    cfg_rd <= 1'h1;
    cfg_addr <= a;
    @(posedge clk);
    cfg_rd <= 1'h0;
    @(negedge clk);
    `CHK("valid", 1'h1, cfg_rd_valid)
    `CHK("rdata", e, cfg_rdata)
  endtask : rd
  task automatic wr(sesr_addr_t a, sesr_word_t d, logic [3:0] b);
    @(posedge clk);
    cfg_wr <= 1'h1;
    cfg_addr <= a;
    cfg_wdata <= d;
    cfg_be <= b;
    @(posedge clk);
    cfg_wr <= 1'h0;
    for (int k = 0; k < 4; k++)
      if (b[k] && a == 12'h134) sev[8*k +: 8] = d[8*k +: 8];
    sev &= 32'h00003FEE;
  endtask : wr
  task automatic ev(int n, logic [31:0] pend);
    @(posedge clk);
    err_event <= 32'h1 << n;
    status_pending <= pend;
    @(posedge clk);
    err_event <= '0;
    @(negedge clk);
    `CHK("fatal", act_mask[n] & sev[n], msg_fatal)
    `CHK("nonfatal", act_mask[n] & !sev[n], msg_nonfatal)
    ef += int'(act_mask[n] & sev[n]);
    en += int'(act_mask[n] & !sev[n]);
  endtask : ev
  task automatic close_out();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  initial
  begin
    int r;
    r = $urandom(53);
    repeat (16) @(posedge clk);
    srst <= 1'h0;
    rd(12'h134, 32'h00001340);
    rd(12'h138, 32'h00000000);
    wr(12'h138, '1, 4'hF);
    rd(12'h138, 32'h00000000);
    rd(12'h134, 32'h00001340);
    rd(12'h200, 32'h00000000);
    $display("reset and read-only test done");
    for (int i = 0; i < 8; i++)
    begin
      wr(12'h134, $urandom, 4'($urandom));
      rd(12'h134, sev);
    end
    $display("write mask test done");
    // Both polarities over every class, PCI-X and reserved included
    for (int v = 0; v < 2; v++)
    begin
      wr(12'h134, v ? 32'h00000000 : 32'hFFFFFFFF, 4'hF);
      for (int n = 0; n < 16; n++) ev(n, '0);
    end
    $display("severity class test done");
    ev(9, '1);
    ev(3, '1);
    `CHK("pointer", 5'h09, first_fault_pointer)
    rd(12'h138, 32'h00000009);
    repeat (4) @(posedge clk);
    status_pending <= '0;
    ev(3, '1);
    @(negedge clk);
    `CHK("pointer", 5'h03, first_fault_pointer)
    $display("pointer test done");
    for (int k = 0; k < 4; k++)
    begin
      wr(12'h134, '1, 4'hF);
      @(posedge clk);
      {srst, power_on_reset, global_reset_input, link_reset} <= 4'h1 << k;
      @(posedge clk);
      {srst, power_on_reset, global_reset_input, link_reset} <= 4'h0;
      sev = 32'h00001340;
      rd(12'h134, 32'h00001340);
      rd(12'h138, 32'h00000000);
    end
    `CHK("fatal count", ef, nf)
    `CHK("nonfatal count", en, nn)
    $display("reset source test done");
    close_out();
  end
endmodule : tb_top
